// ### design/adc_frame_consts.vh
`ifndef ADC_FRAME_CONSTS_VH
`define ADC_FRAME_CONSTS_VH

// frame layout
`define FRAME_BITS          16
`define CMD_MSB             15
`define CMD_LSB             12
`define LOWER_ENABLE_POS    11
`define COUNTER_RESET_POS   10
`define LAST_CH_MSB         9
`define LAST_CH_LSB         6
`define RANGE_SELECT_POS    6
`define POWERDOWN_POS       5
`define OUT_FORMAT_POS      4
`define GPIO_DATA_MSB       3

// command field codes
`define CMD_CONTINUE        4'h0
`define CMD_MANUAL          4'h1
`define CMD_AUTO_ONE        4'h2
`define CMD_AUTO_TWO        4'h3
`define CMD_AUTO_TWO_PROG   4'h9

// operating modes
`define MODE_MANUAL         2'h0
`define MODE_AUTO_ONE       2'h1
`define MODE_AUTO_TWO       2'h2

// reset values
`define RST_MODE            2'h0
`define RST_LAST_CHANNEL    4'hF
`define RST_GPIO_DATA       4'h0
`define FIRST_CHANNEL       4'h0

`endif

// ### design/pin_sync.v
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             i_core_clk,
  input  wire             i_sys_rst,
  // pins
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // first stage feeds only the second stage
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule

`default_nettype wire

// ### design/adc_frame_mode_control.v
// Operation
// - a manual, Auto-1 or lower-enabled Auto-2 frame with the power-down bit set powers the device down on the 16th falling SCLK edge, otherwise it runs normally.
// - with the output-format bit at 0 the top output nibble carries the channel address, followed by the 12-bit result.
// - with the output-format bit at 1 the top output nibble carries the general pins three down to zero.
// - the four lowest frame bits drive the general pins configured as outputs, input pins ignore them, and they reset to zero.
// - the Auto-2 sequence depth is fully programmed in a single chip-select frame.
// - command field 1001 selects the sequence-depth register and frame bits nine to six are its data.
// - in Auto-2 the channel counter runs from the first channel up to the last-channel value and then wraps to zero.
// - a programming frame keeps conversions and serial output going and changes neither range nor GPIO data.
// - a continue frame keeps the mode, advancing the counter in automatic modes and holding it in manual mode.
// - a continue frame ignores the lower twelve bits and keeps every previous setting.
// - in an Auto-2 frame the lower-field enable bit lets the lower eleven bits update, otherwise they are kept.
// - in an enabled Auto-2 frame the counter-reset bit returns the channel counter to the first channel.
// - the range-select bit picks the 2.5V range at 0 and the 5V range at 1.
`timescale 1ns/1ns
`default_nettype none
`include "adc_frame_consts.vh"

module adc_frame_mode_control (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_sys_rst,
  // serial link from host
  input  wire        i_cs_n,
  input  wire        i_sclk,
  input  wire        i_sdi,
  output wire        o_sdo,
  // converter side
  input  wire [11:0] i_conv_result,
  output wire [3:0]  o_channel,
  output wire        o_range_5v,
  output wire        o_powerdown,
  output wire [1:0]  o_mode,
  // general pins
  input  wire [3:0]  i_gpio_dir_out,
  input  wire [3:0]  i_gpio_pin,
  output wire [3:0]  o_gpio_out,
  output wire [3:0]  o_gpio_oe_n
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_WAIT  = 3'b100;

  wire [6:0] pins_sync;
  wire       cs_n_s;
  wire       sclk_s;
  wire       sdi_s;
  wire [3:0] gpio_s;

  reg  [2:0]  state_ff;
  reg         sclk_d_ff;
  reg  [15:0] rx_ff;
  reg  [15:0] tx_ff;
  reg  [4:0]  fall_cnt_ff;
  reg  [1:0]  mode_ff;
  reg  [3:0]  channel_ff;
  reg  [3:0]  last_ch_ff;
  reg  [3:0]  gpio_data_ff;
  reg         range_ff;
  reg         pdown_ff;
  reg         format_ff;

  wire        sclk_rise;
  wire        sclk_fall;
  wire        frame_done;
  wire [15:0] frame;
  wire [3:0]  cmd;
  reg  [1:0]  nxt_mode;
  reg  [3:0]  nxt_channel;
  reg         apply_lower;
  reg         ctr_clear;

  pin_sync #(
    .WIDTH (7)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    ({~i_cs_n, i_sclk, i_sdi, i_gpio_pin}),
    .o_sync     (pins_sync)
  );

  // select travels inverted so a cleared synchroniser reads as deselected after reset
  assign cs_n_s = ~pins_sync[6];
  assign sclk_s = pins_sync[5];
  assign sdi_s  = pins_sync[4];
  assign gpio_s = pins_sync[3:0];

  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;
  // the 16th falling edge closes the frame
  assign frame_done = (state_ff == ST_SHIFT) & sclk_fall & ~cs_n_s
                      & (fall_cnt_ff == 5'h0F);
  // last bit is sampled on the preceding rising edge, so rx is complete here
  assign frame = rx_ff;
  assign cmd   = frame[`CMD_MSB:`CMD_LSB];

  function [3:0] advance;
    input [3:0] ch;
    input [3:0] last;
    begin
      advance = (ch == last) ? `FIRST_CHANNEL : ch + 4'h1;
    end
  endfunction

  // next mode, counter and whether lower bits apply
  always @* begin
    nxt_mode    = mode_ff;
    nxt_channel = channel_ff;
    apply_lower = 1'b0;
    ctr_clear   = 1'b0;
    case (cmd)
      `CMD_MANUAL: begin
        nxt_mode    = `MODE_MANUAL;
        apply_lower = 1'b1;
      end
      `CMD_AUTO_ONE: begin
        nxt_mode    = `MODE_AUTO_ONE;
        apply_lower = 1'b1;
      end
      `CMD_AUTO_TWO: begin
        nxt_mode    = `MODE_AUTO_TWO;
        apply_lower = frame[`LOWER_ENABLE_POS];
        ctr_clear   = apply_lower & frame[`COUNTER_RESET_POS];
      end
      default: begin
        // continue and programming frames keep the mode
        nxt_mode = mode_ff;
      end
    endcase
    if (ctr_clear || (nxt_mode == `MODE_AUTO_TWO && mode_ff != `MODE_AUTO_TWO)) begin
      nxt_channel = `FIRST_CHANNEL;
    end else if (nxt_mode == `MODE_AUTO_TWO) begin
      nxt_channel = advance(channel_ff, last_ch_ff);
    end else if (nxt_mode == `MODE_AUTO_ONE) begin
      nxt_channel = channel_ff + 4'h1;
    end else begin
      nxt_channel = channel_ff;
    end
  end

  // link framing and shifting
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_ff    <= ST_IDLE;
      sclk_d_ff   <= 1'b0;
      rx_ff       <= 16'h0000;
      tx_ff       <= 16'h0000;
      fall_cnt_ff <= 5'h00;
    end else begin
      sclk_d_ff <= sclk_s;
      case (state_ff)
        ST_IDLE: begin
          if (!cs_n_s) begin
            state_ff    <= ST_SHIFT;
            fall_cnt_ff <= 5'h00;
            // serial output stays valid in every frame type
            tx_ff <= {(format_ff ? gpio_s : channel_ff), i_conv_result};
          end
        end
        ST_SHIFT: begin
          if (cs_n_s) begin
            // a short frame is dropped without effect
            state_ff <= ST_IDLE;
          end else begin
            if (sclk_rise) begin
              rx_ff <= {rx_ff[14:0], sdi_s};
            end
            if (sclk_fall) begin
              tx_ff       <= {tx_ff[14:0], 1'b0};
              fall_cnt_ff <= fall_cnt_ff + 5'h01;
            end
            if (frame_done) begin
              state_ff <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // one frame per select low; wait for deselect before rearming
          if (cs_n_s) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // settings apply only at frame completion
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      mode_ff      <= `RST_MODE;
      channel_ff   <= `FIRST_CHANNEL;
      last_ch_ff   <= `RST_LAST_CHANNEL;
      gpio_data_ff <= `RST_GPIO_DATA;
      range_ff     <= 1'b0;
      pdown_ff     <= 1'b0;
      format_ff    <= 1'b0;
    end else if (frame_done) begin
      mode_ff    <= nxt_mode;
      channel_ff <= nxt_channel;
      if (cmd == `CMD_AUTO_TWO_PROG) begin
        last_ch_ff <= frame[`LAST_CH_MSB:`LAST_CH_LSB];
      end
      // continue frames leave all of this alone
      if (apply_lower) begin
        range_ff  <= frame[`RANGE_SELECT_POS];
        pdown_ff  <= frame[`POWERDOWN_POS];
        format_ff <= frame[`OUT_FORMAT_POS];
        gpio_data_ff <= (frame[`GPIO_DATA_MSB:0] & i_gpio_dir_out)
                        | (gpio_data_ff & ~i_gpio_dir_out);
      end
    end
  end

  assign o_sdo       = tx_ff[15];
  assign o_channel   = channel_ff;
  assign o_range_5v  = range_ff;
  assign o_powerdown = pdown_ff;
  assign o_mode      = mode_ff;
  assign o_gpio_out  = gpio_data_ff;
  assign o_gpio_oe_n = ~i_gpio_dir_out;

endmodule

`default_nettype wire

// ### bench/adc_frame_mode_control_sva.sv
`timescale 1ns/1ns
`default_nettype none
module frame_ctl_chk (
  input wire logic       i_core_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_cs_n,
  input wire logic       i_sclk,
  input wire logic [3:0] i_gpio_dir_out,
  input wire logic [3:0] o_channel,
  input wire logic       o_range_5v,
  input wire logic       o_powerdown,
  input wire logic [1:0] o_mode,
  input wire logic [3:0] o_gpio_out,
  input wire logic [3:0] o_gpio_oe_n
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // six idle cycles cover the synchroniser lag after the last edge
  sequence s_idle;
    i_cs_n [*6];
  endsequence
  sequence s_stay(m);
    o_mode == m && $past(o_mode) == m;
  endsequence
  a_oe_dir: assert property (o_gpio_oe_n == ~i_gpio_dir_out) else $error("oe");
  a_rst_vals: assert property ($fell(i_sys_rst) |->
    {o_mode, o_channel, o_powerdown, o_range_5v, o_gpio_out} == 12'h0) else $error("rst");
  a_idle_hold: assert property (s_idle |-> $stable({o_mode, o_range_5v,
    o_powerdown, o_gpio_out})) else $error("idle change");
  a_in_pin_kept: assert property ($stable(i_gpio_dir_out) |->
    ((o_gpio_out ^ $past(o_gpio_out)) & ~i_gpio_dir_out) == 4'h0) else $error("in pin");
  a_auto2_step: assert property (s_stay(2'h2) ##0 $changed(o_channel) |->
    o_channel == $past(o_channel) + 4'h1 || o_channel == 4'h0) else $error("step");
  a_manual_hold: assert property (s_stay(2'h0) |-> $stable(o_channel)) else $error("hold");
  a_enter_auto2: assert property (o_mode == 2'h2 && $past(o_mode) != 2'h2 |->
    o_channel == 4'h0) else $error("entry");
  a_pd_frame_end: assert property ($rose(o_powerdown) |->
    !$past(i_sclk, 2) && !$past(i_sclk, 3)) else $error("pd edge");
endmodule
bind adc_frame_mode_control frame_ctl_chk u_chk (.i_core_clk, .i_sys_rst, .i_cs_n, .i_sclk,
  .i_gpio_dir_out, .o_channel, .o_range_5v, .o_powerdown, .o_mode, .o_gpio_out, .o_gpio_oe_n);
`default_nettype wire

// ### bench/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input  wire logic i_core_clk,
  input  wire logic i_sdo,
  output var  logic o_cs_n,
  output var  logic o_sclk,
  output var  logic o_sdi
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end
  // n below 16 aborts the frame early; sclk stays still between frames
  task automatic send(input logic [15:0] w, input int n, output logic [15:0] rx);
    rx = 16'h0;
    o_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      o_sdi <= w[15-i];
      repeat (4) @(posedge i_core_clk);
      o_sclk <= 1'b1;
      rx = {rx[14:0], i_sdo};
      repeat (4) @(posedge i_core_clk);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_core_clk);
    o_cs_n <= 1'b1;
    // released data line flips so a stale bit cannot pass
    o_sdi <= ~o_sdi;
    repeat (8) @(posedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// ### bench/adc_frame_mode_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adc_frame_mode_control_tb;
  logic i_core_clk, i_sys_rst, i_cs_n, i_sclk, i_sdi, o_sdo, o_range_5v, o_powerdown;
  logic [11:0] i_conv_result;
  logic [3:0] o_channel, i_gpio_dir_out, i_gpio_pin, o_gpio_out, o_gpio_oe_n;
  logic [1:0] o_mode;
  logic [15:0] rx;
  int error_cnt, n_tests;
  adc_frame_mode_control DUT (.i_core_clk, .i_sys_rst, .i_cs_n, .i_sclk, .i_sdi, .o_sdo,
    .i_conv_result, .o_channel, .o_range_5v, .o_powerdown, .o_mode, .i_gpio_dir_out,
    .i_gpio_pin, .o_gpio_out, .o_gpio_oe_n);
  spi_host_model host (.i_core_clk, .i_sdo(o_sdo), .o_cs_n(i_cs_n), .o_sclk(i_sclk),
    .o_sdi(i_sdi));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic fr(input logic [15:0] w, input int n = 16);
    host.send(w, n, rx);
  endtask
  task automatic t_reset;
    chk("reset", {o_mode, o_powerdown, o_range_5v, o_gpio_out, o_channel}, 16'h0);
    chk("oe", o_gpio_oe_n, 16'h000C);
  endtask
  task automatic t_prog;
    fr(16'h908F);
    chk("prog", {o_mode, o_range_5v, o_gpio_out}, 16'h0);
    chk("sdo", rx, {4'h0, i_conv_result});
  endtask
  task automatic t_seq;
    fr(16'h3845);
    chk("entry", {o_mode, o_range_5v, o_gpio_out, o_channel}, {3'h5, 8'h10});
    for (int k = 1; k < 5; k++) begin
      fr(16'h0FFF);
      chk("chan", {o_channel, rx[15:12]}, {4'(k % 3), 4'((k - 1) % 3)});
      chk("keep", {o_mode, o_range_5v, o_powerdown, o_gpio_out}, {4'hA, 4'h1});
    end
  endtask
  task automatic t_ctl;
    fr(16'h3C40);
    chk("clr", o_channel, 4'h0);
    fr(16'h3850);
    fr(16'h0000);
    chk("fmt", rx, {i_gpio_pin, i_conv_result});
    fr(16'h3030);
    chk("kept", {o_powerdown, o_range_5v}, 2'b01);
    fr(16'h3860);
    chk("pd_on", o_powerdown, 1'b1);
    fr(16'h3840);
    chk("pd_off", o_powerdown, 1'b0);
  endtask
  task automatic t_modes;
    logic [3:0] c0;
    fr(16'h1000, 8);
    chk("abort", o_mode, 2'h2);
    fr(16'h2000);
    chk("auto1", o_mode, 2'h1);
    fr(16'h1000);
    c0 = o_channel;
    fr(16'h0000);
    chk("hold", {o_mode, o_channel}, {2'h0, c0});
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  initial begin
    i_sys_rst = 1'b1;
    i_gpio_dir_out = 4'h3;
    i_gpio_pin = 4'hA;
    i_conv_result = 12'hA5C;
    repeat (12) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    t_reset;
    t_prog;
    t_seq;
    t_ctl;
    t_modes;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge i_core_clk);
    error_cnt++;
    close_out;
  end
endmodule
`default_nettype wire
